// *** dv/asr_line_props.sv ***
// Assertions on the line and the software read port of the receiver pair.
// Assumes a 4-clock bit time (bit_period_i of 3) and the one shared clock.
`timescale 1ns/100ps
module asr_line_props (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // Line side
    input  wire logic        line,
    input  wire logic        send_i,
    input  wire logic        busy_o,
    // Software port
    input  wire logic [3:0]  addr_i,
    input  wire logic        rd_i,
    input  wire logic [15:0] rdata_o
);
    import asr_pkg::*;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Line rests high whenever no frame is on it
    property p_idle; !busy_o |-> line; endproperty
    a_idle: assert property (p_idle) else $error("line low outside a frame");
    // Accepted request starts a frame with a low start bit
    property p_start; send_i && !busy_o |=> !line && busy_o; endproperty
    a_start: assert property (p_start) else $error("no start bit after request");
    // Start bit lasts a full bit time of 4 clocks
    property p_start_len; $rose(busy_o) |-> !line [*4]; endproperty
    a_start_len: assert property (p_start_len) else $error("start bit too short");
    // Frame of 10 or 11 bits ends within a bounded window
    property p_frame; $rose(busy_o) |-> ##35 busy_o ##[1:12] !busy_o; endproperty
    a_frame: assert property (p_frame) else $error("frame length wrong");
    // Read data only stands in the cycle after a read
    property p_rd_idle; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    // Buffer read shows only the low eight data bits
    property p_data_hi; $past(rd_i) && $past(addr_i) == ASR_OFF_DATA |-> rdata_o[15:8] == 8'h00; endproperty
    a_data_hi: assert property (p_data_hi) else $error("buffer read upper bits set");
    // Status holds only full, framing, overrun and ninth bit
    property p_stat_hi; $past(rd_i) && $past(addr_i) == ASR_OFF_STATUS |-> rdata_o[15:4] == 12'h000; endproperty
    a_stat_hi: assert property (p_stat_hi) else $error("status upper bits set");
    // Unmapped reads return zero
    property p_unmapped; $past(rd_i) && $past(addr_i) > ASR_OFF_IEN |-> rdata_o == 16'h0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // asr_line_props

// *** dv/tb_top.sv ***
// Self-checking bench: transmitter and receiver joined by the line interface.
// Assumes divisor 0 with both rate selects set, giving 4 clocks per bit.
`timescale 1ns/100ps
module tb_top;
    import asr_pkg::*;
    // ------------------------------------------------------------
    // Signals and case table
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [8:0]  d9;
        logic        nine;
        logic [15:0] st;
        logic [7:0]  dat;
    } asr_row_t;
    logic        clk_i        = 1'b0;
    logic        sys_rst_i    = 1'b1;
    logic [3:0]  addr_i       = 4'h0;
    logic [15:0] wdata_i      = 16'h0000;
    logic        wr_i         = 1'b0;
    logic        rd_i         = 1'b0;
    logic        send_i       = 1'b0;
    logic        nine_i       = 1'b0;
    logic        bad_stop_i   = 1'b0;
    logic [8:0]  data_i       = 9'h000;
    logic [21:0] bit_period_i = 22'h000003;
    logic [15:0] rdata_o;
    logic [15:0] v;
    logic        irq_o;
    logic        busy_o;
    int          failures     = 0;
    int          checks       = 0;
    int          n;
    // Control, character, nine-bit, expected status, expected data
    asr_row_t rows [8] = '{
        '{8'hD1, 9'h0A5, 1'b0, 16'h0001, 8'hA5},
        '{8'hD5, 9'h13C, 1'b1, 16'h0009, 8'h3C},
        '{8'hD5, 9'h081, 1'b1, 16'h0001, 8'h81},
        '{8'hF5, 9'h155, 1'b1, 16'h0009, 8'h55},
        '{8'hF5, 9'h066, 1'b1, 16'h0008, 8'h00},
        '{8'hD5, 9'h077, 1'b1, 16'h0001, 8'h77},
        '{8'hC1, 9'h012, 1'b0, 16'h0000, 8'h00},
        '{8'hD0, 9'h034, 1'b0, 16'h0000, 8'h00}
    };
    asr_line_if line_w ();
    asr_receiver asr_receiver_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .line_if(line_w), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
    asr_transmitter asr_transmitter_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bit_period_i(bit_period_i), .send_i(send_i), .nine_i(nine_i),
        .data_i(data_i), .bad_stop_i(bad_stop_i), .busy_o(busy_o), .line_if(line_w));
    asr_line_props asr_line_props_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .line(line_w.line), .send_i(send_i), .busy_o(busy_o),
        .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o));
    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic irqc(input logic e);
        repeat (2) @(posedge clk_i);
        #1 chk({15'h0000, irq_o}, {15'h0000, e});
    endtask
    // Frame out, then margin for synchroniser and stop-bit sampling
    task automatic send(input logic [8:0] d, input logic nn, input logic bad);
        @(posedge clk_i);
        data_i     <= d;
        nine_i     <= nn;
        bad_stop_i <= bad;
        send_i     <= 1'b1;
        @(posedge clk_i);
        send_i     <= 1'b0;
        #1;
        for (n = 0; busy_o === 1'b1 && n < 100; n++) @(posedge clk_i);
        if (n == 100) begin
            failures++;
            stop_test();
        end
        repeat (8) @(posedge clk_i);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(ASR_OFF_CTRL);
        chk(v, {8'h00, ASR_CTRL_RST});
        rd(ASR_OFF_STATUS);
        chk(v, 16'h0000);
        wr(4'hF, 16'hFFFF);
        rd(4'hF);
        chk(v, 16'h0000);
        wr(ASR_OFF_BAUD, ASR_BAUD_RST);
        foreach (rows[i]) begin
            wr(ASR_OFF_CTRL, {8'h00, rows[i].ctrl});
            send(rows[i].d9, rows[i].nine, 1'b0);
            rd(ASR_OFF_STATUS);
            chk(v, rows[i].st);
            if (rows[i].st[0]) begin
                rd(ASR_OFF_DATA);
                chk(v, {8'h00, rows[i].dat});
            end
        end
        // Inverted idle line reads as back-to-back low frames
        wr(ASR_OFF_CTRL, 16'h00D9);
        repeat (45) @(posedge clk_i);
        rd(ASR_OFF_STATUS);
        chk(v, 16'h0003);
        rd(ASR_OFF_DATA);
        chk(v, 16'h0000);
        wr(ASR_OFF_CTRL, 16'h00C1);
        // Low stop bit still delivers, flagged
        wr(ASR_OFF_CTRL, 16'h00D1);
        send(9'h0C3, 1'b0, 1'b1);
        rd(ASR_OFF_STATUS);
        chk(v, 16'h0003);
        rd(ASR_OFF_DATA);
        chk(v, 16'h00C3);
        // Second character lands on an unread buffer and is lost
        send(9'h011, 1'b0, 1'b0);
        send(9'h022, 1'b0, 1'b0);
        rd(ASR_OFF_STATUS);
        chk(v, 16'h0005);
        rd(ASR_OFF_DATA);
        chk(v, 16'h0011);
        rd(ASR_OFF_STATUS);
        chk(v, 16'h0004);
        wr(ASR_OFF_CTRL, 16'h00C1);
        wr(ASR_OFF_CTRL, 16'h00D1);
        rd(ASR_OFF_STATUS);
        chk(v, 16'h0000);
        // Sticky events, cleared by reading them
        rd(ASR_OFF_IRQST);
        chk(v, 16'h0007);
        rd(ASR_OFF_IRQST);
        chk(v, 16'h0000);
        wr(ASR_OFF_IRQMSK, 16'h0001);
        send(9'h05A, 1'b0, 1'b0);
        irqc(1'b1);
        rd(ASR_OFF_IRQST);
        chk(v, 16'h0001);
        irqc(1'b0);
        wr(ASR_OFF_IRQMSK, 16'h0000);
        wr(ASR_OFF_IEN, 16'h0003);
        irqc(1'b0);
        wr(ASR_OFF_IEN, 16'h0007);
        irqc(1'b1);
        rd(ASR_OFF_DATA);
        chk(v, 16'h005A);
        irqc(1'b0);
        // Reset in mid-run returns flags, control and interrupt to rest
        send(9'h0F0, 1'b0, 1'b0);
        irqc(1'b1);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        irqc(1'b0);
        rd(ASR_OFF_STATUS);
        chk(v, 16'h0000);
        rd(ASR_OFF_CTRL);
        chk(v, {8'h00, ASR_CTRL_RST});
        stop_test();
    end
endmodule // tb_top

// *** hw/asr_receiver.sv ***
// Asynchronous serial receiver with 9-bit address detection.
// Assumes the line is asynchronous to clk_i and idle high (uninverted).
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module asr_receiver (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // Serial line
    asr_line_if.rx_end       line_if,
    // Software register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    // Interrupt
    output logic             irq_o
);
    import asr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ASR_IDLE  = 2'b00,
        ASR_START = 2'b01,
        ASR_DATA  = 2'b11,
        ASR_STOP  = 2'b10
    } asr_state_t;

    typedef struct packed {
        logic [ASR_SYNC_STAGES-1:0] sync;
        asr_state_t  st;
        logic [15:0] baud;
        logic [7:0]  ctrl;
        logic [2:0]  ien;
        logic [15:0] div_cnt;
        logic [5:0]  ovs_cnt;
        logic [3:0]  bit_cnt;
        logic [8:0]  shift;
        logic [7:0]  buf_data;
        logic        buf_bit9;
        logic        full;
        logic        ferr;
        logic        overrun_error_flag;
        logic [2:0]  evt;
        logic [2:0]  mask;
        logic [15:0] rdata;
        logic        irq;
    } asr_rx_state_t;

    asr_rx_state_t r, nx;

    logic       line_s;
    logic       tick;
    logic       half;
    logic       rx_on;
    logic       nine;
    logic       addr_mode;
    logic [5:0] ovs_top;
    logic [3:0] n_bits;
    logic [2:0] ev_set;
    logic       deliver;
    logic       rd_data;
    logic       rd_evt;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        nx      = r;
        nx.sync = {r.sync[ASR_SYNC_STAGES-2:0], line_if.line};
        // Only the last stage is read; invert applied after sync
        line_s  = r.sync[ASR_SYNC_STAGES-1] ^ r.ctrl[ASR_C_INV];
        rx_on   = r.ctrl[ASR_C_PORT_EN] & ~r.ctrl[ASR_C_SYNC]
                  & r.ctrl[ASR_C_CONT_RX];
        nine      = r.ctrl[ASR_C_NINE];
        addr_mode = nine & r.ctrl[ASR_C_ADDR_DET];
        n_bits    = nine ? 4'h9 : 4'h8;
        // Rate select picks oversampling, as 16-bit mode narrows the ratio
        unique case ({r.ctrl[ASR_C_B16], r.ctrl[ASR_C_HSPEED]})
            2'b00:   ovs_top = ASR_OVS_LOW;
            2'b11:   ovs_top = ASR_OVS_HIGH;
            default: ovs_top = ASR_OVS_MID;
        endcase
        // Divisor: 8-bit mode ignores the high byte
        tick = (r.div_cnt == 16'h0000);
        if (tick || r.st == ASR_IDLE) begin
            nx.div_cnt = r.ctrl[ASR_C_B16] ? r.baud : {8'h00, r.baud[7:0]};
        end else begin
            nx.div_cnt = r.div_cnt - 16'h0001;
        end
        half    = tick && (r.ovs_cnt == {1'b0, ovs_top[5:1]});
        ev_set  = 3'b000;
        deliver = 1'b0;

        // Frame sequencer, samples at mid-bit
        unique case (r.st)
            ASR_IDLE: begin
                nx.ovs_cnt = 6'h00;
                if (rx_on && !line_s) begin
                    nx.st = ASR_START;
                end
            end
            ASR_START: begin
                if (tick) begin
                    nx.ovs_cnt = r.ovs_cnt + 6'h01;
                end
                if (half) begin
                    nx.ovs_cnt = 6'h00;
                    nx.bit_cnt = 4'h0;
                    nx.st      = line_s ? ASR_IDLE : ASR_DATA;
                end
            end
            ASR_DATA: begin
                if (tick) begin
                    nx.ovs_cnt = (r.ovs_cnt == ovs_top) ? 6'h00 : r.ovs_cnt + 6'h01;
                    if (r.ovs_cnt == ovs_top) begin
                        // LSB first: shift down from the top of the frame width
                        if (nine) begin
                            nx.shift = {line_s, r.shift[8:1]};
                        end else begin
                            nx.shift = {1'b0, line_s, r.shift[7:1]};
                        end
                        nx.bit_cnt = r.bit_cnt + 4'h1;
                        if (r.bit_cnt == n_bits - 4'h1) begin
                            nx.st = ASR_STOP;
                        end
                    end
                end
            end
            ASR_STOP: begin
                if (tick) begin
                    nx.ovs_cnt = r.ovs_cnt + 6'h01;
                end
                if (tick && r.ovs_cnt == ovs_top) begin
                    nx.st = ASR_IDLE;
                    // Address mode drops ninth-bit-clear characters
                    if (!addr_mode || r.shift[8]) begin
                        if (r.full || r.overrun_error_flag) begin
                            nx.overrun_error_flag   = 1'b1;
                            ev_set[ASR_E_OVERRUN_ERROR_FLAG] = 1'b1;
                        end else begin
                            deliver = 1'b1;
                        end
                    end
                end
            end
        endcase
        if (!rx_on) begin
            nx.st = ASR_IDLE;
        end

        // Register port
        rd_data = rd_i && (addr_i == ASR_OFF_DATA);
        rd_evt  = rd_i && (addr_i == ASR_OFF_IRQST);
        if (wr_i) begin
            unique case (addr_i)
                ASR_OFF_CTRL:   nx.ctrl = wdata_i[7:0];
                ASR_OFF_BAUD:   nx.baud = wdata_i;
                ASR_OFF_IRQMSK: nx.mask = wdata_i[2:0];
                ASR_OFF_IEN:    nx.ien  = wdata_i[2:0];
                default:        ;
            endcase
        end
        if (!r.ctrl[ASR_C_CONT_RX]) begin
            nx.overrun_error_flag = 1'b0;
        end
        if (rd_data) begin
            nx.full = 1'b0;
        end
        if (deliver) begin
            // Both frame widths leave the first data bit at position 0
            nx.buf_data = r.shift[7:0];
            nx.buf_bit9 = nine & r.shift[8];
            nx.ferr     = ~line_s;
            nx.full     = 1'b1;
            ev_set[ASR_E_RX]   = 1'b1;
            ev_set[ASR_E_FERR] = ~line_s;
        end
        // Read clears, a simultaneous event survives
        nx.evt = (rd_evt ? 3'b000 : r.evt) | ev_set;

        nx.rdata = 16'h0000;
        if (rd_i) begin
            unique case (addr_i)
                ASR_OFF_CTRL:   nx.rdata = {8'h00, r.ctrl};
                ASR_OFF_BAUD:   nx.rdata = r.baud;
                ASR_OFF_STATUS: nx.rdata = {12'h000, r.buf_bit9, r.overrun_error_flag, r.ferr, r.full};
                ASR_OFF_DATA:   nx.rdata = {8'h00, r.buf_data};
                ASR_OFF_IRQST:  nx.rdata = {13'h0000, r.evt};
                ASR_OFF_IRQMSK: nx.rdata = {13'h0000, r.mask};
                ASR_OFF_IEN:    nx.rdata = {13'h0000, r.ien};
                default:        nx.rdata = 16'h0000;
            endcase
        end
        // Receive flag also gated by the three enables
        nx.irq = (|(nx.evt & r.mask)) | (nx.full & (&r.ien));
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            r          <= '0;
            r.sync     <= '1;
            r.st       <= ASR_IDLE;
            r.baud     <= ASR_BAUD_RST;
            r.ctrl     <= ASR_CTRL_RST;
        end else begin
            r <= nx;
        end
    end

    assign rdata_o = r.rdata;
    assign irq_o   = r.irq;
endmodule // asr_receiver

// *** hw/asr_transmitter.sv ***
// Remote transmitter model for the line: sends one framed character on request.
// Assumes the receiver uses the same divisor and oversampling setting.
`timescale 1ns/100ps
module asr_transmitter (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // Bit period in clocks, minus one
    input  wire logic [21:0] bit_period_i,
    // Character request
    input  wire logic        send_i,
    input  wire logic        nine_i,
    input  wire logic [8:0]  data_i,
    input  wire logic        bad_stop_i,
    output logic             busy_o,
    // Serial line
    asr_line_if.tx_end       line_if
);
    import asr_pkg::*;

    typedef struct packed {
        logic        busy;
        logic        line;
        logic [21:0] cnt;
        logic [3:0]  idx;
        logic [10:0] frame;
        logic [3:0]  last;
    } asr_tx_state_t;

    asr_tx_state_t r, nx;

    // ------------------------------------------------------------
    // Frame shifter: start, LSB-first data, stop
    // ------------------------------------------------------------
    always_comb begin
        nx = r;
        if (!r.busy) begin
            if (send_i) begin
                nx.busy  = 1'b1;
                nx.cnt   = bit_period_i;
                nx.idx   = 4'h0;
                nx.last  = nine_i ? 4'hA : 4'h9;
                // Stop placed right after the data bits
                nx.frame = nine_i ? {~bad_stop_i, data_i, 1'b0}
                                  : {1'b1, ~bad_stop_i, data_i[7:0], 1'b0};
                nx.line  = 1'b0;
            end
        end else if (r.cnt == 22'h000000) begin
            nx.cnt = bit_period_i;
            if (r.idx == r.last) begin
                nx.busy = 1'b0;
                nx.line = 1'b1;
            end else begin
                nx.idx  = r.idx + 4'h1;
                nx.line = r.frame[r.idx + 4'h1];
            end
        end else begin
            nx.cnt = r.cnt - 22'h000001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            r      <= '0;
            r.line <= 1'b1;
        end else begin
            r <= nx;
        end
    end

    assign line_if.line = r.line;
    assign busy_o       = r.busy;
endmodule // asr_transmitter

// *** shared/asr_line_if.sv ***
// Line between the remote transmitter and the receiver.
// Assumes both ends sit on the same clock; the wire is idle high.
`timescale 1ns/100ps
interface asr_line_if;
    logic line;   // Serial line level as driven by the transmitter
    modport tx_end (output line);
    modport rx_end (input line);
endinterface : asr_line_if

// *** shared/asr_pkg.sv ***
// Shared constants for the async serial receiver and its line-side transmitter.
// Assumes one 40 MHz system clock shared by both ends.
package asr_pkg;
    // ------------------------------------------------------------
    // Register offsets (software port, word index)
    // ------------------------------------------------------------
    localparam logic [3:0] ASR_OFF_CTRL   = 4'h0;
    localparam logic [3:0] ASR_OFF_BAUD   = 4'h1;
    localparam logic [3:0] ASR_OFF_STATUS = 4'h2;
    localparam logic [3:0] ASR_OFF_DATA   = 4'h3;
    localparam logic [3:0] ASR_OFF_IRQST  = 4'h4;
    localparam logic [3:0] ASR_OFF_IRQMSK = 4'h5;
    localparam logic [3:0] ASR_OFF_IEN    = 4'h6;
    // ------------------------------------------------------------
    // Control bit positions
    // ------------------------------------------------------------
    localparam int ASR_C_PORT_EN  = 0;
    localparam int ASR_C_SYNC     = 1;
    localparam int ASR_C_NINE     = 2;
    localparam int ASR_C_INV      = 3;
    localparam int ASR_C_CONT_RX  = 4;
    localparam int ASR_C_ADDR_DET = 5;
    localparam int ASR_C_HSPEED   = 6;
    localparam int ASR_C_B16      = 7;
    // Status bit positions
    localparam int ASR_S_FULL     = 0;
    localparam int ASR_S_FERR     = 1;
    localparam int ASR_S_OVERRUN_ERROR_FLAG     = 2;
    localparam int ASR_S_BIT9     = 3;
    // Interrupt-enable bit positions
    localparam int ASR_I_RXIE     = 0;
    localparam int ASR_I_PEIE     = 1;
    localparam int ASR_I_GIE      = 2;
    // Sticky event bits
    localparam int ASR_E_RX       = 0;
    localparam int ASR_E_FERR     = 1;
    localparam int ASR_E_OVERRUN_ERROR_FLAG     = 2;
    // Reset values
    localparam logic [15:0] ASR_BAUD_RST = 16'h0000;
    localparam logic [7:0]  ASR_CTRL_RST = 8'h00;
    // Oversampling ratios for the rate selects
    localparam logic [5:0] ASR_OVS_LOW  = 6'h3F;  // 64 - 1
    localparam logic [5:0] ASR_OVS_MID  = 6'h0F;  // 16 - 1
    localparam logic [5:0] ASR_OVS_HIGH = 6'h03;  // 4 - 1
    localparam int ASR_SYNC_STAGES = 2;
endpackage : asr_pkg
